// >>> rtl/dms_pkg.sv
// Package with register map, field positions, timing counts and state types of the DLL switch sequencer.
package dms_pkg;
  // ===========================================================
  // Register offsets (byte addresses, one 32-bit word each)
  // ===========================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MR0 = 8'h04;
  localparam logic [7:0] OFS_MR1 = 8'h08;
  localparam logic [7:0] OFS_MR2 = 8'h0C;
  localparam logic [7:0] OFS_DIV_ON = 8'h10;
  localparam logic [7:0] OFS_DIV_OFF = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PER_SUM = 8'h1C;
  localparam logic [7:0] OFS_HIGH_SUM = 8'h20;
  // ===========================================================
  // Field positions and reset values
  // ===========================================================
  localparam int CTRL_START = 0;
  localparam int CTRL_TO_OFF = 1;
  localparam int CTRL_ZQ_EN = 2;
  localparam int MR1_DLL_DIS = 0;
  localparam int MR0_DLL_RST = 8;
  localparam int MR0_CL_LSB = 4;
  localparam int MR0_CL_BIT0 = 2;
  localparam int MR2_CWL_LSB = 3;
  localparam logic [2:0] CL6_CODE = 3'h2;
  localparam logic [2:0] CWL6_CODE = 3'h1;
  localparam logic [15:0] MR0_RST = 16'h0000;
  localparam logic [15:0] MR1_RST = 16'h0000;
  localparam logic [15:0] MR2_RST = 16'h0000;
  localparam logic [7:0] DIV_ON_RST = 8'h04;
  localparam logic [7:0] DIV_OFF_RST = 8'h08;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam int ZQ_LONG_BIT = 10;
  // ===========================================================
  // Command pin codes {cs_n, ras_n, cas_n, we_n}
  // ===========================================================
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  // ===========================================================
  // Waits in link clock cycles (nCK)
  // ===========================================================
  localparam logic [15:0] T_MOD = 16'h000C;
  localparam logic [15:0] T_MRD = 16'h0004;
  localparam logic [15:0] T_CKSRE = 16'h0005;
  localparam logic [15:0] T_CKSRX = 16'h0005;
  localparam logic [15:0] T_XS = 16'h0010;
  localparam logic [15:0] T_DLLK = 16'h0200;
  localparam logic [15:0] T_ZQOPER = 16'h0100;
  localparam logic [7:0] WIN_LAST = 8'hC7;
  // ===========================================================
  // Types
  // ===========================================================
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_PREP = 4'b0001,
    ST_SRE = 4'b0010,
    ST_CHG = 4'b0011,
    ST_SRX = 4'b0100,
    ST_MR1ON = 4'b0101,
    ST_MR0R = 4'b0110,
    ST_MR2 = 4'b0111,
    ST_MR0 = 4'b1000,
    ST_ZQ = 4'b1001,
    ST_WAIT = 4'b1010,
    ST_DONE = 4'b1011
  } dms_state_type;
  typedef enum logic [1:0] {
    DLL_ON = 2'b00,
    DLL_OFF = 2'b01,
    DLL_LOCK = 2'b10
  } dms_dll_type;
endpackage

// >>> rtl/dms_ck_if.sv
// Interface between the sequencer and the link clock generator.
`timescale 1ns/100ps
interface dms_ck_if;
  logic [7:0] half;
  logic load;
  logic ck;
  logic ck_rise;
  logic ck_fall;
  logic [19:0] per_sum;
  logic [19:0] high_sum;
  modport gen(input half, input load, output ck, output ck_rise, output ck_fall,
              output per_sum, output high_sum);
  modport seq(output half, output load, input ck, input ck_rise, input ck_fall,
              input per_sum, input high_sum);
endinterface

// >>> rtl/dms_ckgen.sv
// Link clock divider with period and high-time sums over a 200-period averaging window.
`timescale 1ns/100ps
module dms_ckgen
  import dms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dms_ck_if.gen ck_if
);
  typedef struct packed {
    logic [7:0] half;
    logic [7:0] cnt;
    logic ck;
    logic rise;
    logic fall;
    logic [7:0] win;
    logic [19:0] per_acc;
    logic [19:0] high_acc;
    logic [19:0] per_sum;
    logic [19:0] high_sum;
  } dms_gen_type;

  dms_gen_type q;
  dms_gen_type n;

  // ===========================================================
  // Divider and window sums
  // ===========================================================
  always_comb begin
    n = q;
    n.rise = 1'b0;
    n.fall = 1'b0;
    n.per_acc = q.per_acc + 20'h00001;
    n.high_acc = q.high_acc + {19'h00000, q.ck};
    if (ck_if.load) begin
      n.half = ck_if.half;
      n.cnt = 8'h00;
    end else if (q.cnt + 8'h01 >= q.half) begin
      n.cnt = 8'h00;
      n.ck = !q.ck;
      n.rise = !q.ck;
      n.fall = q.ck;
    end else begin
      n.cnt = q.cnt + 8'h01;
    end
    // Sums close after 200 rising-to-rising periods; software divides them.
    if (n.rise) begin
      if (q.win == WIN_LAST) begin
        n.win = 8'h00;
        n.per_sum = n.per_acc;
        n.high_sum = n.high_acc;
        n.per_acc = 20'h00000;
        n.high_acc = 20'h00000;
      end else begin
        n.win = q.win + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{half: DIV_ON_RST, default: '0};
    end else begin
      q <= n;
    end
  end

  assign ck_if.ck = q.ck;
  assign ck_if.ck_rise = q.rise;
  assign ck_if.ck_fall = q.fall;
  assign ck_if.per_sum = q.per_sum;
  assign ck_if.high_sum = q.high_sum;

  // ===========================================================
  // Checks
  // ===========================================================
  property p_win_close;
    @(posedge pclk) disable iff (!presetn)
      $changed(q.per_sum) |-> $past(q.win) == WIN_LAST && q.win == 8'h00;
  endproperty
  a_win_close: assert property (p_win_close) else $error("window closed early");
endmodule

// >>> rtl/dms_seq.sv
// DDR3 DLL on/off switching sequencer with an APB register file and link clock divider.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module dms_seq
  import dms_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic banks_idle,
  output logic ddr_ck,
  output logic ddr_cke,
  output logic ddr_cs_n,
  output logic ddr_ras_n,
  output logic ddr_cas_n,
  output logic ddr_we_n,
  output logic [2:0] ddr_ba,
  output logic [ADDR_W-1:0] ddr_addr,
  output logic ddr_odt,
  output logic busy,
  output logic dll_cmd_block
);
  typedef struct packed {
    dms_state_type state;
    dms_state_type ret;
    logic [15:0] cnt;
    dms_dll_type dll;
    logic [15:0] dllk;
    logic to_off;
    logic zq_en;
    logic done;
    logic err;
    logic [15:0] mr0;
    logic [15:0] mr1;
    logic [15:0] mr2;
    logic [7:0] div_on;
    logic [7:0] div_off;
    logic cke;
    logic odt;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [15:0] addr;
    logic load;
    logic [31:0] rdata;
    logic rerr;
  } dms_seq_type;

  dms_seq_type q;
  dms_seq_type n;
  dms_ck_if ck_if();

  dms_ckgen u_ckgen (
    .pclk(pclk),
    .presetn(presetn),
    .ck_if(ck_if)
  );

  // Puts one command on the pins and waits the given number of link cycles.
  function automatic dms_seq_type issue(input dms_seq_type s, input logic [3:0] c,
                                        input logic [2:0] b, input logic [15:0] a,
                                        input logic [15:0] w, input dms_state_type r);
    dms_seq_type t;
    t = s;
    t.cmd = c;
    t.ba = b;
    t.addr = a;
    t.cnt = w;
    t.ret = r;
    t.state = ST_WAIT;
    return t;
  endfunction

  // ===========================================================
  // Register access and sequencer
  // ===========================================================
  logic wr_en;
  logic rd_setup;
  logic [15:0] mr0_val;
  logic [15:0] mr2_val;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  always_comb begin
    n = q;
    n.load = 1'b0;
    // DLL-off mode supports only CL=6 and CWL=6; the fields are forced there.
    mr0_val = q.mr0;
    mr0_val[MR0_DLL_RST] = 1'b0;
    mr2_val = q.mr2;
    if (q.to_off) begin
      mr0_val[MR0_CL_LSB +: 3] = CL6_CODE;
      mr0_val[MR0_CL_BIT0] = 1'b0;
      mr2_val[MR2_CWL_LSB +: 3] = CWL6_CODE;
    end
    if (rd_setup) begin
      n.rerr = 1'b0;
      case (paddr)
        OFS_CTRL: n.rdata = {29'h00000000, q.zq_en, q.to_off, 1'b0};
        OFS_MR0: n.rdata = {16'h0000, q.mr0};
        OFS_MR1: n.rdata = {16'h0000, q.mr1};
        OFS_MR2: n.rdata = {16'h0000, q.mr2};
        OFS_DIV_ON: n.rdata = {24'h000000, q.div_on};
        OFS_DIV_OFF: n.rdata = {24'h000000, q.div_off};
        OFS_STATUS: n.rdata = {20'h00000, q.state, 2'h0, q.dll != DLL_ON, q.dll,
                               q.err, q.done, q.state != ST_IDLE};
        OFS_PER_SUM: n.rdata = {12'h000, ck_if.per_sum};
        OFS_HIGH_SUM: n.rdata = {12'h000, ck_if.high_sum};
        default: begin
          n.rdata = 32'h00000000;
          n.rerr = 1'b1;
        end
      endcase
    end
    if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          if (pwdata[CTRL_START] && q.state != ST_IDLE) begin
            n.err = 1'b1;
          end else if (pwdata[CTRL_START]) begin
            n.state = ST_PREP;
            n.to_off = pwdata[CTRL_TO_OFF];
            n.zq_en = pwdata[CTRL_ZQ_EN];
            n.err = 1'b0;
            n.done = 1'b0;
          end
        end
        OFS_MR0: if (q.state == ST_IDLE) n.mr0 = pwdata[15:0];
        OFS_MR1: if (q.state == ST_IDLE) n.mr1 = pwdata[15:0];
        OFS_MR2: if (q.state == ST_IDLE) n.mr2 = pwdata[15:0];
        OFS_DIV_ON: if (q.state == ST_IDLE) n.div_on = pwdata[7:0];
        OFS_DIV_OFF: if (q.state == ST_IDLE) n.div_off = pwdata[7:0];
        default: n.err = q.err;
      endcase
    end
    if (ck_if.ck_rise) begin
      if (q.cnt != 16'h0000) n.cnt = q.cnt - 16'h0001;
      if (q.dllk != 16'h0000) n.dllk = q.dllk - 16'h0001;
    end
    if (q.dll == DLL_LOCK && q.dllk == 16'h0000) n.dll = DLL_ON;
    // Termination stays off for the whole procedure, so ODT never rises.
    n.odt = 1'b0;
    if (ck_if.ck_fall) begin
      n.cmd = CMD_NOP;
      case (q.state)
        ST_PREP: begin
          if (banks_idle && q.to_off) begin
            n = issue(n, CMD_MRS, BA_MR1, q.mr1 | 16'h0001, T_MOD, ST_SRE);
            n.dll = DLL_OFF;
          end else if (banks_idle) begin
            n.state = ST_SRE;
          end
        end
        ST_SRE: begin
          // The entry rise itself is counted, so one extra rise keeps the full tCKSRE.
          n = issue(n, CMD_REF, 3'h0, 16'h0000, T_CKSRE + 16'h0001, ST_CHG);
          n.cke = 1'b0;
        end
        ST_SRX: begin
          n.cke = 1'b1;
          n = issue(n, CMD_NOP, 3'h0, 16'h0000, T_XS, q.to_off ? ST_MR2 : ST_MR1ON);
        end
        ST_MR1ON: begin
          n = issue(n, CMD_MRS, BA_MR1, q.mr1 & 16'hFFFE, T_MRD, ST_MR0R);
        end
        ST_MR0R: begin
          n = issue(n, CMD_MRS, BA_MR0, q.mr0 | 16'h0100, T_MRD, ST_MR2);
          n.dll = DLL_LOCK;
          // The reset command's own rise is counted, so lock ends a full tDLLK later.
          n.dllk = T_DLLK + 16'h0001;
        end
        ST_MR2: n = issue(n, CMD_MRS, BA_MR2, mr2_val, T_MRD, ST_MR0);
        ST_MR0: n = issue(n, CMD_MRS, BA_MR0, mr0_val, T_MOD, q.zq_en ? ST_ZQ : ST_DONE);
        ST_ZQ: n = issue(n, CMD_ZQ, 3'h0, 16'h0400, T_ZQOPER, ST_DONE);
        ST_WAIT: if (q.cnt == 16'h0000) n.state = q.ret;
        ST_DONE: begin
          if (q.dll != DLL_LOCK) begin
            n.state = ST_IDLE;
            n.done = 1'b1;
          end
        end
        default: n.state = q.state;
      endcase
    end
    // The divider only retunes while the device sits in self refresh.
    if (q.state == ST_CHG) begin
      n.load = 1'b1;
      n.cnt = T_CKSRX;
      n.ret = ST_SRX;
      n.state = ST_WAIT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{state: ST_IDLE, ret: ST_IDLE, dll: DLL_ON, mr0: MR0_RST, mr1: MR1_RST,
             mr2: MR2_RST, div_on: DIV_ON_RST, div_off: DIV_OFF_RST, cke: 1'b1,
             cmd: CMD_NOP, default: '0};
    end else begin
      q <= n;
    end
  end

  assign ck_if.half = q.to_off ? q.div_off : q.div_on;
  assign ck_if.load = q.load;
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = q.rerr;
  assign ddr_ck = ck_if.ck;
  assign ddr_cke = q.cke;
  assign {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} = q.cmd;
  assign ddr_ba = q.ba;
  assign ddr_addr = q.addr[ADDR_W-1:0];
  assign ddr_odt = q.odt;
  assign busy = q.state != ST_IDLE;
  assign dll_cmd_block = q.dll != DLL_ON;

  // ===========================================================
  // Checks: link cycle counters since the last MRS, CKE rise and load
  // ===========================================================
  logic new_cmd;
  logic new_mrs;
  logic [15:0] gap_q;
  logic [15:0] xs_q;
  logic [15:0] stab_q;
  logic cke_p_q;
  logic [3:0] cmd_p_q;

  assign new_cmd = q.cmd != CMD_NOP && cmd_p_q == CMD_NOP;
  assign new_mrs = new_cmd && q.cmd == CMD_MRS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 16'hFFFF;
      xs_q <= 16'hFFFF;
      stab_q <= 16'h0000;
      cke_p_q <= 1'b1;
      cmd_p_q <= CMD_NOP;
    end else begin
      cke_p_q <= q.cke;
      cmd_p_q <= q.cmd;
      if (new_mrs) gap_q <= {15'h0000, ck_if.ck_rise};
      else if (ck_if.ck_rise && gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
      if (q.cke && !cke_p_q) xs_q <= {15'h0000, ck_if.ck_rise};
      else if (ck_if.ck_rise && xs_q != 16'hFFFF) xs_q <= xs_q + 16'h0001;
      if (q.load) stab_q <= 16'h0000;
      else if (ck_if.ck_rise && stab_q != 16'hFFFF) stab_q <= stab_q + 16'h0001;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_off_idle;
    new_mrs && q.ba == BA_MR1 && q.addr[MR1_DLL_DIS] |-> !ddr_odt && $past(banks_idle);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("DLL off write when not idle");
  property p_sre_gap;
    new_cmd && q.cmd == CMD_REF |-> !q.cke && gap_q >= T_MOD;
  endproperty
  a_sre_gap: assert property (p_sre_gap) else $error("self refresh entry before tMOD");
  property p_load_sr;
    q.load |-> !q.cke && $past(!q.cke, 2) && q.cmd == CMD_NOP;
  endproperty
  a_load_sr: assert property (p_load_sr) else $error("clock changed outside self refresh");
  property p_srx_stable;
    $rose(q.cke) |-> stab_q >= T_CKSRX;
  endproperty
  a_srx_stable: assert property (p_srx_stable) else $error("exit before stable clock");
  property p_cke_hold;
    $fell(q.cke) |-> gap_q >= T_MOD && q.dll != DLL_LOCK && q.state == ST_WAIT;
  endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("CKE dropped early");
  property p_odt_low;
    busy |-> !ddr_odt;
  endproperty
  a_odt_low: assert property (p_odt_low) else $error("ODT high during switch");
  property p_xs_wait;
    new_mrs |-> xs_q >= T_XS && gap_q >= T_MRD;
  endproperty
  a_xs_wait: assert property (p_xs_wait) else $error("mode write too early");
  property p_dll_reset;
    new_mrs && q.ba == BA_MR0 && q.addr[MR0_DLL_RST] |->
      q.dll == DLL_LOCK && q.dllk == T_DLLK + 16'h0001;
  endproperty
  a_dll_reset: assert property (p_dll_reset) else $error("DLL reset not tracked");
  property p_lock_wait;
    $fell(busy) && !q.to_off |-> !dll_cmd_block && q.dllk == 16'h0000 && q.done;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("done before tDLLK");
  property p_cl6;
    new_mrs && q.ba == BA_MR0 && q.dll == DLL_OFF |->
      q.addr[MR0_CL_LSB +: 3] == CL6_CODE && !q.addr[MR0_CL_BIT0];
  endproperty
  a_cl6: assert property (p_cl6) else $error("CL not six in DLL off");

  c_off_done: cover property ($fell(busy) && q.to_off);
  c_on_done: cover property ($fell(busy) && !q.to_off);
  c_zq: cover property (new_cmd && q.cmd == CMD_ZQ);
endmodule

// >>> testbench/dms_dram_model.sv
// Behavioural DDR3 device model that decodes link commands and counts protocol faults.
`timescale 1ns/100ps
module dms_dram_model
  import dms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ck,
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic odt,
  output logic dll_off,
  output logic [7:0] rst_cnt,
  output logic [7:0] zq_cnt,
  output logic [15:0] cmd_cnt,
  output logic [15:0] viol,
  output logic [15:0] per,
  output logic [15:0] lock_cnt,
  output logic [13:0] mr0,
  output logic [13:0] mr1,
  output logic [13:0] mr2
);
  logic ck_d, in_sr, fix, chg, bad;
  logic [1:0] nr;
  logic [15:0] pc, s_mrs, s_x, s_sr, stab;
  assign chg = nr == 2'd3 && pc + 16'h0001 != per;
  // Every check runs at a link clock rise, seen one pclk after the rise.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ck_d, in_sr, fix, dll_off, nr} <= '0;
      {rst_cnt, zq_cnt, cmd_cnt, viol, per, pc, lock_cnt, mr0, mr1, mr2} <= '0;
      {s_mrs, s_x} <= '1;
      {s_sr, stab} <= '0;
    end else begin
      bad = 1'b0;
      ck_d <= ck;
      pc <= pc + 16'h0001;
      if (ck && !ck_d) begin
        pc <= 16'h0000;
        per <= pc + 16'h0001;
        if (nr != 2'd3) nr <= nr + 2'd1;
        if (s_mrs != 16'hFFFF) s_mrs <= s_mrs + 16'h0001;
        if (s_x != 16'hFFFF) s_x <= s_x + 16'h0001;
        if (lock_cnt != 16'h0000) lock_cnt <= lock_cnt - 16'h0001;
        if (odt) bad = 1'b1;
        if (in_sr) begin
          s_sr <= s_sr + 16'h0001;
          stab <= chg ? 16'h0001 : stab + 16'h0001;
          if (chg) fix <= 1'b1;
          if (chg && !fix && s_sr < T_CKSRE) bad = 1'b1;
          if (cke) begin
            in_sr <= 1'b0;
            s_x <= 16'h0000;
            if (stab < T_CKSRX - 16'h0001) bad = 1'b1;
          end
        end else begin
          if (chg) bad = 1'b1;
          if (!cke) begin
            if (cmd == CMD_REF && s_mrs >= T_MOD - 16'h0001) begin
              in_sr <= 1'b1;
              {s_sr, stab, fix} <= '0;
            end else begin
              bad = 1'b1;
            end
          end else if (cmd != CMD_NOP) begin
            cmd_cnt <= cmd_cnt + 16'h0001;
            if (s_x < T_XS - 16'h0001) bad = 1'b1;
            if (cmd == CMD_MRS) begin
              s_mrs <= 16'h0000;
              if (s_mrs < T_MRD - 16'h0001) bad = 1'b1;
              case (ba)
                BA_MR0: begin
                  mr0 <= addr;
                  if (dll_off && addr[MR0_CL_LSB +: 3] != CL6_CODE) bad = 1'b1;
                  if (dll_off && addr[MR0_CL_BIT0]) bad = 1'b1;
                  if (addr[MR0_DLL_RST]) begin
                    rst_cnt <= rst_cnt + 8'h01;
                    lock_cnt <= T_DLLK;
                    if (dll_off) bad = 1'b1;
                  end
                end
                BA_MR1: begin
                  mr1 <= addr;
                  dll_off <= addr[MR1_DLL_DIS];
                end
                BA_MR2: begin
                  mr2 <= addr;
                  if (dll_off && addr[MR2_CWL_LSB +: 3] != CWL6_CODE) bad = 1'b1;
                end
                default: bad = 1'b1;
              endcase
            end else if (cmd == CMD_ZQ) begin
              zq_cnt <= zq_cnt + 8'h01;
              if (!addr[ZQ_LONG_BIT] || s_mrs < T_MOD - 16'h0001) bad = 1'b1;
            end else begin
              bad = 1'b1;
            end
          end
        end
        if (bad) viol <= viol + 16'h0001;
      end
    end
  end
endmodule

// >>> testbench/test_dms_seq.sv
// Self-checking testbench of the DLL switch sequencer with a device model.
`timescale 1ns/100ps
module test_dms_seq
  import dms_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, banks_idle, er;
  logic [7:0] paddr, rst_cnt, zq_cnt;
  logic [31:0] pwdata, prdata, rd;
  logic ddr_ck, ddr_cke, cs_n, ras_n, cas_n, we_n, ddr_odt, busy, blk, dll_off;
  logic [2:0] ddr_ba;
  logic [13:0] ddr_addr, mr0, mr1, mr2;
  logic [15:0] cmd_cnt, viol, per, lock_cnt, c0;
  int n_mismatch, cmp_count, cyc;
  logic [7:0] ofs [7] = '{OFS_CTRL, OFS_MR0, OFS_MR1, OFS_MR2, OFS_DIV_ON, OFS_DIV_OFF, OFS_STATUS};
  logic [31:0] rv [7] = '{0, 0, 0, 0, 32'(DIV_ON_RST), 32'(DIV_OFF_RST), 0};

  dms_seq #(.ADDR_W(14)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .banks_idle(banks_idle), .ddr_ck(ddr_ck), .ddr_cke(ddr_cke),
    .ddr_cs_n(cs_n), .ddr_ras_n(ras_n), .ddr_cas_n(cas_n), .ddr_we_n(we_n), .ddr_ba(ddr_ba),
    .ddr_addr(ddr_addr), .ddr_odt(ddr_odt), .busy(busy), .dll_cmd_block(blk));
  dms_dram_model u_dram (.pclk(pclk), .presetn(presetn), .ck(ddr_ck), .cke(ddr_cke),
    .cmd({cs_n, ras_n, cas_n, we_n}), .ba(ddr_ba), .addr(ddr_addr), .odt(ddr_odt),
    .dll_off(dll_off), .rst_cnt(rst_cnt), .zq_cnt(zq_cnt), .cmd_cnt(cmd_cnt), .viol(viol),
    .per(per), .lock_cnt(lock_cnt), .mr0(mr0), .mr1(mr1), .mr2(mr2));

  always #50 pclk = ~pclk;

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic sts_chk(input logic [31:0] exp);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h0000003F, exp);
  endtask

  task automatic wait_done;
    repeat (2) @(posedge pclk);
    while (busy !== 1'b0) @(negedge pclk);
  endtask

  // Averaging window sums once the link clock has run steadily for a full window.
  task automatic t_sums(input logic [31:0] p);
    repeat (p * 410) @(posedge pclk);
    rd_chk(OFS_PER_SUM, p * 200);
    rd_chk(OFS_HIGH_SUM, p * 100);
  endtask

  task automatic t_reset;
    @(negedge pclk);
    chk({ddr_cke, cs_n, ras_n, cas_n, we_n, ddr_odt, busy, blk}, {1'b1, CMD_NOP, 3'b000});
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_chk(ofs[i], rv[i]);
      chk(32'(er), 32'h0);
    end
    apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    sts_chk(32'h0);
    rd_chk(8'h24, 32'h0);
    chk(32'(er), 32'h1);
    rd_chk(8'h02, 32'h0);
    chk(32'(er), 32'h1);
    $display("reset test finished");
  endtask

  task automatic t_off;
    apb(1'b1, OFS_MR0, 32'h00000A70);
    apb(1'b1, OFS_MR1, 32'h00000044);
    apb(1'b1, OFS_MR2, 32'h00000238);
    apb(1'b1, OFS_CTRL, 32'h00000003);
    repeat (2) @(negedge pclk);
    chk(32'(busy), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h00000003);
    apb(1'b1, OFS_DIV_ON, 32'h00000006);
    apb(1'b1, OFS_MR0, 32'h00001111);
    wait_done;
    chk(32'(viol), 32'h0);
    chk(32'(dll_off), 32'h1);
    chk(32'(mr1), 32'h00000045);
    chk(32'(mr0), 32'h00000A20);
    chk(32'(mr2), 32'h00000208);
    chk(32'(per), 32'(DIV_OFF_RST) * 2);
    chk(32'(zq_cnt), 32'h0);
    chk(32'(blk), 32'h1);
    sts_chk(32'h0000002E);
    rd_chk(OFS_DIV_ON, 32'(DIV_ON_RST));
    rd_chk(OFS_MR0, 32'h00000A70);
    t_sums(32'(DIV_OFF_RST) * 2);
    $display("dll off test finished");
  endtask

  task automatic t_on;
    banks_idle <= 1'b0;
    c0 = cmd_cnt;
    apb(1'b1, OFS_CTRL, 32'h00000005);
    repeat (300) @(negedge pclk);
    chk({cmd_cnt, 15'h0, ddr_cke}, {c0, 16'h0001});
    chk(32'(busy), 32'h1);
    @(posedge pclk);
    banks_idle <= 1'b1;
    while (rst_cnt !== 8'h01) @(negedge pclk);
    chk({31'h0, blk}, 32'h1);
    chk(32'(dll_off), 32'h0);
    wait_done;
    chk(32'(viol), 32'h0);
    chk(32'(rst_cnt), 32'h1);
    chk(32'(zq_cnt), 32'h1);
    chk(32'(lock_cnt), 32'h0);
    chk(32'(mr1), 32'h00000044);
    chk(32'(mr0), 32'h00000A70);
    chk(32'(per), 32'(DIV_ON_RST) * 2);
    chk(32'(blk), 32'h0);
    sts_chk(32'h00000002);
    t_sums(32'(DIV_ON_RST) * 2);
    $display("dll on test finished");
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    banks_idle = 1'b1;
    t_reset;
    t_off;
    t_on;
    test_done;
  end
endmodule
